/* File: design/dppa_pkg.sv */
package dppa_pkg;

  // ---------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------
  localparam int         DPPA_BUS_W     = 8;
  localparam int         DPPA_CTRL_WR_W = 6;
  localparam int         DPPA_SIDES     = 2;
  localparam logic [7:0] DPPA_REG_RESET = 8'h00;

  // ---------------------------------------------------------------------
  // Side control register field positions
  // ---------------------------------------------------------------------
  localparam int CTL_IRQ1_EN_BIT    = 0;
  localparam int CTL_EDGE1_BIT      = 1;
  localparam int CTL_DIR_ACCESS_BIT = 2;
  localparam int CTL_IRQ2_EN_BIT    = 3;
  localparam int CTL_EDGE2_BIT      = 4;
  localparam int CTL_OUT2_BIT       = 5;
  localparam int CTL_FLAG2_BIT      = 6;
  localparam int CTL_FLAG1_BIT      = 7;

  // ---------------------------------------------------------------------
  // Register select codes, as {register_select_1, register_select_0}
  // ---------------------------------------------------------------------
  localparam logic [1:0] SEL_DATA_A = 2'h0;
  localparam logic [1:0] SEL_CTRL_A = 2'h1;
  localparam logic [1:0] SEL_DATA_B = 2'h2;
  localparam logic [1:0] SEL_CTRL_B = 2'h3;

  // ---------------------------------------------------------------------
  // Decoded register locations
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    LOC_A_DATA = 3'h0,
    LOC_A_DIR  = 3'h1,
    LOC_A_CTRL = 3'h2,
    LOC_B_DATA = 3'h3,
    LOC_B_DIR  = 3'h4,
    LOC_B_CTRL = 3'h5
  } dppa_loc_t;

  // Output modes of ctl_x2, as control bits {5,4,3}.
  localparam logic [2:0] OUT2_HANDSHAKE = 3'h4;
  localparam logic [2:0] OUT2_PULSE     = 3'h5;

endpackage

/* File: design/dppa_ctl2_out.sv */
`timescale 1ns/1ps

module dppa_ctl2_out
  import dppa_pkg::*;
#(
  parameter bit SIDE_B = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] mode,
  input  wire logic       strobe_lead,
  input  wire logic       strobe_trail,
  input  wire logic       data_read,
  input  wire logic       data_write,
  input  wire logic       ctl1_event,
  output logic            ctl2_level,
  output logic            ctl2_oe
);

  // ---------------------------------------------------------------------
  // Handshake sequencing
  // ---------------------------------------------------------------------
  logic arm_reg;
  logic pend_reg;
  logic level_reg;
  logic clear_evt;
  logic set_evt;
  logic step;

  // Side A answers reads on the trailing strobe edge, side B answers
  // writes on the leading edge of the following strobe.
  assign step      = SIDE_B ? strobe_lead : strobe_trail;
  assign clear_evt = SIDE_B ? (strobe_lead & arm_reg) : data_read;
  assign set_evt   = (mode == OUT2_PULSE) ? (step & pend_reg) : ctl1_event;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arm_reg <= 1'b0;
    end else if (data_write) begin
      arm_reg <= 1'b1;
    end else if (strobe_lead) begin
      arm_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
    end else if (clear_evt) begin
      pend_reg <= 1'b1;
    end else if (step) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_reg <= 1'b0;
    end else if (mode[2] && mode[1]) begin
      level_reg <= mode[0];
    end else if (mode[2] && set_evt) begin
      level_reg <= 1'b1;
    end else if (mode[2] && clear_evt) begin
      level_reg <= 1'b0;
    end
  end

  assign ctl2_level = level_reg;
  assign ctl2_oe    = mode[2];

endmodule

/* File: design/dppa_top.sv */
`timescale 1ns/1ps

module dppa_top
  import dppa_pkg::*;
#(
  parameter int BUS_W = DPPA_BUS_W
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             chip_select_0,
  input  wire logic             chip_select_1,
  input  wire logic             chip_select_2_n,
  input  wire logic             register_select_0,
  input  wire logic             register_select_1,
  input  wire logic             read_write,
  input  wire logic             enable_strobe,
  input  wire logic [BUS_W-1:0] host_data_in,
  output logic      [BUS_W-1:0] host_data_out,
  output logic                  host_data_oe,
  output logic                  irq_side_a_n_out,
  output logic                  irq_side_a_n_oe,
  output logic                  irq_side_b_n_out,
  output logic                  irq_side_b_n_oe,
  input  wire logic [BUS_W-1:0] port_a_lines_in,
  output logic      [BUS_W-1:0] port_a_lines_out,
  output logic      [BUS_W-1:0] port_a_lines_oe,
  input  wire logic [BUS_W-1:0] port_b_lines_in,
  output logic      [BUS_W-1:0] port_b_lines_out,
  output logic      [BUS_W-1:0] port_b_lines_oe,
  input  wire logic             ctl_a1,
  input  wire logic             ctl_b1,
  input  wire logic             ctl_a2_in,
  output logic                  ctl_a2_out,
  output logic                  ctl_a2_oe,
  input  wire logic             ctl_b2_in,
  output logic                  ctl_b2_out,
  output logic                  ctl_b2_oe
);

  // ---------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------
  // The control word and the host bus share one byte, so only 8 works.
  if (BUS_W != DPPA_BUS_W) begin : g_bad_width
    $error("dppa_top: BUS_W must equal the 8-bit host bus width.");
  end

  // ---------------------------------------------------------------------
  // Register address decoding
  // ---------------------------------------------------------------------
  function automatic dppa_loc_t dppa_decode(
    input logic [1:0] sel,
    input logic       a_dir_access,
    input logic       b_dir_access
  );
    dppa_loc_t loc;
    loc = LOC_A_CTRL;
    unique case (sel)
      SEL_DATA_A: loc = a_dir_access ? LOC_A_DATA : LOC_A_DIR;
      SEL_CTRL_A: loc = LOC_A_CTRL;
      SEL_DATA_B: loc = b_dir_access ? LOC_B_DATA : LOC_B_DIR;
      SEL_CTRL_B: loc = LOC_B_CTRL;
    endcase
    return loc;
  endfunction

  // ---------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------
  logic [BUS_W-1:0]          out_reg   [DPPA_SIDES];
  logic [BUS_W-1:0]          dir_reg   [DPPA_SIDES];
  logic [DPPA_CTRL_WR_W-1:0] ctrl_reg  [DPPA_SIDES];
  logic                      flag1_reg [DPPA_SIDES];
  logic                      flag2_reg [DPPA_SIDES];
  logic                      samp1_reg [DPPA_SIDES];
  logic                      samp2_reg [DPPA_SIDES];
  logic                      seen_reg  [DPPA_SIDES];
  logic                      strobe_prev_reg;
  logic [BUS_W-1:0]          rd_data_reg;

  // ---------------------------------------------------------------------
  // Strobe edges and bus cycle qualification
  // ---------------------------------------------------------------------
  logic      strobe_lead;
  logic      strobe_trail;
  logic      selected;
  logic      wr_evt;
  logic      rd_evt;
  dppa_loc_t loc;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strobe_prev_reg <= 1'b0;
    end else begin
      strobe_prev_reg <= enable_strobe;
    end
  end

  assign strobe_lead  = enable_strobe & ~strobe_prev_reg;
  assign strobe_trail = ~enable_strobe & strobe_prev_reg;
  // Selects are taken as stable through the pulse, so they are read live.
  assign selected     = chip_select_0 & chip_select_1 &
                        ~chip_select_2_n;
  assign loc          = dppa_decode({register_select_1, register_select_0},
                                    ctrl_reg[0][CTL_DIR_ACCESS_BIT],
                                    ctrl_reg[1][CTL_DIR_ACCESS_BIT]);
  assign wr_evt       = strobe_trail & selected &
                        ~read_write;
  assign rd_evt       = strobe_trail & selected & read_write;

  // ---------------------------------------------------------------------
  // Port output and direction registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_reg[0] <= DPPA_REG_RESET;
      out_reg[1] <= DPPA_REG_RESET;
      dir_reg[0] <= DPPA_REG_RESET;
      dir_reg[1] <= DPPA_REG_RESET;
    end else if (wr_evt) begin
      unique case (loc)
        LOC_A_DATA: out_reg[0] <= host_data_in;
        LOC_A_DIR:  dir_reg[0] <= host_data_in;
        LOC_B_DATA: out_reg[1] <= host_data_in;
        LOC_B_DIR:  dir_reg[1] <= host_data_in;
        default:    ;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Side control registers, writable bits only
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg[0] <= DPPA_REG_RESET[DPPA_CTRL_WR_W-1:0];
      ctrl_reg[1] <= DPPA_REG_RESET[DPPA_CTRL_WR_W-1:0];
    end else if (wr_evt && loc == LOC_A_CTRL) begin
      ctrl_reg[0] <= host_data_in[DPPA_CTRL_WR_W-1:0];
    end else if (wr_evt && loc == LOC_B_CTRL) begin
      ctrl_reg[1] <= host_data_in[DPPA_CTRL_WR_W-1:0];
    end
  end

  // ---------------------------------------------------------------------
  // Per-side control lines, flags and interrupt requests
  // ---------------------------------------------------------------------
  logic ctl1_in  [DPPA_SIDES];
  logic ctl2_in  [DPPA_SIDES];
  logic ctl2_out [DPPA_SIDES];
  logic ctl2_oe  [DPPA_SIDES];
  logic irq_req  [DPPA_SIDES];

  assign ctl1_in[0] = ctl_a1;
  assign ctl1_in[1] = ctl_b1;
  assign ctl2_in[0] = ctl_a2_in;
  assign ctl2_in[1] = ctl_b2_in;

  for (genvar s = 0; s < DPPA_SIDES; s++) begin : g_side
    logic ev1;
    logic ev2;
    logic data_rd;
    logic data_wr;
    logic ctl2_input;

    // Lines are sampled once per strobe, so an edge is only seen if a
    // strobe lands on each side of it; glitches between strobes vanish.
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        samp1_reg[s] <= 1'b0;
        samp2_reg[s] <= 1'b0;
        seen_reg[s]  <= 1'b0;
      end else if (strobe_lead) begin
        samp1_reg[s] <= ctl1_in[s];
        samp2_reg[s] <= ctl2_in[s];
        seen_reg[s]  <= 1'b1;
      end
    end

    assign ctl2_input = ~ctrl_reg[s][CTL_OUT2_BIT];
    assign ev1 = strobe_lead & seen_reg[s] &
                 (ctl1_in[s] != samp1_reg[s]) &
                 (ctl1_in[s] == ctrl_reg[s][CTL_EDGE1_BIT]);
    assign ev2 = strobe_lead & seen_reg[s] & ctl2_input &
                 (ctl2_in[s] != samp2_reg[s]) &
                 (ctl2_in[s] == ctrl_reg[s][CTL_EDGE2_BIT]);
    assign data_rd = rd_evt & (loc == (s == 0 ? LOC_A_DATA : LOC_B_DATA));
    assign data_wr = wr_evt & (loc == (s == 0 ? LOC_A_DATA : LOC_B_DATA));

    // A new edge in the clearing cycle keeps its flag set.
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        flag1_reg[s] <= 1'b0;
      end else if (ev1) begin
        flag1_reg[s] <= 1'b1;
      end else if (data_rd) begin
        flag1_reg[s] <= 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        flag2_reg[s] <= 1'b0;
      end else if (ev2) begin
        flag2_reg[s] <= 1'b1;
      end else if (data_rd) begin
        flag2_reg[s] <= 1'b0;
      end
    end

    // Level gating, so a later enable raises a pending request at once.
    assign irq_req[s] =
      (flag1_reg[s] & ctrl_reg[s][CTL_IRQ1_EN_BIT]) |
      (flag2_reg[s] & ctrl_reg[s][CTL_IRQ2_EN_BIT] & ctl2_input);

    dppa_ctl2_out #(
      .SIDE_B (s == 1)
    ) u_ctl2 (
      .clk          (clk),
      .rst_n        (rst_n),
      .mode         (ctrl_reg[s][CTL_OUT2_BIT:CTL_IRQ2_EN_BIT]),
      .strobe_lead  (strobe_lead),
      .strobe_trail (strobe_trail),
      .data_read    (data_rd),
      .data_write   (data_wr),
      .ctl1_event   (ev1),
      .ctl2_level   (ctl2_out[s]),
      .ctl2_oe      (ctl2_oe[s])
    );
  end

  // ---------------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------------
  logic [BUS_W-1:0] rd_mux;
  logic [BUS_W-1:0] port_b_view;

  // Port B output bits come from the latch, so loaded pins read true.
  assign port_b_view = (dir_reg[1] & out_reg[1]) |
                       (~dir_reg[1] & port_b_lines_in);

  always_comb begin
    rd_mux = DPPA_REG_RESET;
    unique case (loc)
      LOC_A_DATA: rd_mux = port_a_lines_in;
      LOC_A_DIR:  rd_mux = dir_reg[0];
      LOC_A_CTRL: rd_mux = {flag1_reg[0], flag2_reg[0], ctrl_reg[0]};
      LOC_B_DATA: rd_mux = port_b_view;
      LOC_B_DIR:  rd_mux = dir_reg[1];
      LOC_B_CTRL: rd_mux = {flag1_reg[1], flag2_reg[1], ctrl_reg[1]};
      default:    rd_mux = DPPA_REG_RESET;
    endcase
  end

  // The data byte follows the pins while the strobe is high and freezes
  // on its fall, which is when the host latches it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_reg <= DPPA_REG_RESET;
    end else if (enable_strobe && selected && read_write) begin
      rd_data_reg <= rd_mux;
    end
  end

  assign host_data_out = rd_data_reg;
  assign host_data_oe  = selected & read_write &
                         enable_strobe;

  // ---------------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------------
  assign port_a_lines_out = out_reg[0];
  assign port_a_lines_oe  = dir_reg[0];
  assign port_b_lines_out = out_reg[1];
  assign port_b_lines_oe  = dir_reg[1];

  assign ctl_a2_out = ctl2_out[0];
  assign ctl_a2_oe  = ctl2_oe[0];
  assign ctl_b2_out = ctl2_out[1];
  assign ctl_b2_oe  = ctl2_oe[1];

  // Open drain: the level is always low, only the enable moves.
  assign irq_side_a_n_out = 1'b0;
  assign irq_side_a_n_oe  = irq_req[0];
  assign irq_side_b_n_out = 1'b0;
  assign irq_side_b_n_oe  = irq_req[1];

endmodule

/* File: dv/dppa_chk.sv */
`timescale 1ns/1ps

module dppa_chk
  import dppa_pkg::*;
#(
  parameter int BUS_W = 8
) (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             chip_select_0,
  input wire logic             chip_select_1,
  input wire logic             chip_select_2_n,
  input wire logic             register_select_0,
  input wire logic             register_select_1,
  input wire logic             read_write,
  input wire logic             enable_strobe,
  input wire logic [BUS_W-1:0] host_data_in,
  input wire logic [BUS_W-1:0] host_data_out,
  input wire logic             host_data_oe,
  input wire logic             irq_side_a_n_out,
  input wire logic             irq_side_a_n_oe,
  input wire logic             irq_side_b_n_out,
  input wire logic             irq_side_b_n_oe,
  input wire logic [BUS_W-1:0] port_a_lines_oe,
  input wire logic [BUS_W-1:0] port_a_lines_out,
  input wire logic [BUS_W-1:0] port_b_lines_oe,
  input wire logic [BUS_W-1:0] port_b_lines_out,
  input wire logic             ctl_a2_out,
  input wire logic             ctl_a2_oe,
  input wire logic             ctl_b2_out,
  input wire logic             ctl_b2_oe
);
  // ----------------------------------------
  // Mirror of the host bus state
  // ----------------------------------------
  logic             stb_reg;
  logic             b_acc_reg;
  logic [5:0]       ca_reg;
  logic [BUS_W-1:0] wd_reg;
  wire  [1:0]       sel = {register_select_1, register_select_0};
  wire              hit = chip_select_0 & chip_select_1 & ~chip_select_2_n;
  wire              take = stb_reg & ~enable_strobe & hit;
  wire              tw = take & ~read_write;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stb_reg <= 1'b0;
    end else begin
      stb_reg <= enable_strobe;
    end
  end

  // The mirror follows writes so select decoding can be predicted.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ca_reg <= 6'h00;
    end else if (tw && sel == SEL_CTRL_A) begin
      ca_reg <= host_data_in[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      b_acc_reg <= 1'b0;
    end else if (tw && sel == SEL_CTRL_B) begin
      b_acc_reg <= host_data_in[2];
    end
  end

  always_ff @(posedge clk) begin
    if (tw) begin
      wd_reg <= host_data_in;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_OE_DECODE: assert property (
    host_data_oe == (hit & read_write & enable_strobe))
    else $error("read driver enable wrong");
  AST_IRQ_PULL_LOW: assert property (
    !irq_side_a_n_out && !irq_side_b_n_out)
    else $error("request line would drive high");
  AST_RESET_CLEAR: assert property (
    disable iff (1'b0) !rst_n |=> !(|{port_a_lines_oe, port_b_lines_oe,
      port_a_lines_out, port_b_lines_out, ctl_a2_oe, ctl_b2_oe, ctl_a2_out,
      ctl_b2_out, irq_side_a_n_oe, irq_side_b_n_oe}))
    else $error("outputs not cleared by reset");
  AST_CTRL_A_WRITE: assert property (
    tw && sel == SEL_CTRL_A |-> ##[1:2] ctl_a2_oe == wd_reg[5] &&
      (wd_reg[5:4] != 2'h3 || ctl_a2_out == wd_reg[3]))
    else $error("side a control write not applied");
  AST_CTRL_B_WRITE: assert property (
    tw && sel == SEL_CTRL_B |-> ##[1:2] ctl_b2_oe == wd_reg[5] &&
      (wd_reg[5:4] != 2'h3 || ctl_b2_out == wd_reg[3]))
    else $error("side b control write not applied");
  AST_DIR_WRITE: assert property (
    tw && sel == SEL_DATA_A && !ca_reg[2] |-> ##[1:2]
      port_a_lines_oe == wd_reg)
    else $error("direction write not applied");
  AST_OUT_WRITE: assert property (
    tw && sel == SEL_DATA_B && b_acc_reg |-> ##[1:2]
      port_b_lines_out == wd_reg)
    else $error("output latch write not applied");
  AST_IRQ_GATED: assert property (
    !ca_reg[0] && !ca_reg[3] && $past(!ca_reg[0] && !ca_reg[3])
      |-> !irq_side_a_n_oe)
    else $error("request active while disabled");
  AST_READ_CLEAR: assert property (
    take && read_write && sel == SEL_DATA_A && ca_reg[2] ##1
      !enable_strobe ##1 !enable_strobe |-> !irq_side_a_n_oe)
    else $error("data read did not clear side a");
  AST_DATA_HOLD: assert property (
    !enable_strobe && $past(!enable_strobe) |-> $stable(host_data_out))
    else $error("read data moved without strobe");
  AST_NO_STRAY: assert property (
    $changed(port_a_lines_oe) |-> $past(tw) || $past(tw, 2))
    else $error("direction changed without write");
endmodule

bind dppa_top dppa_chk #(.BUS_W(BUS_W)) u_chk (
  .clk, .rst_n, .chip_select_0, .chip_select_1, .chip_select_2_n,
  .register_select_0, .register_select_1, .read_write, .enable_strobe,
  .host_data_in, .host_data_out, .host_data_oe, .irq_side_a_n_out,
  .irq_side_a_n_oe, .irq_side_b_n_out, .irq_side_b_n_oe, .port_a_lines_oe,
  .port_a_lines_out, .port_b_lines_oe, .port_b_lines_out, .ctl_a2_out,
  .ctl_a2_oe, .ctl_b2_out, .ctl_b2_oe
);

/* File: dv/dppa_periph.sv */
`timescale 1ns/1ps

module dppa_periph (
  input  wire logic [7:0] a_out,
  input  wire logic [7:0] a_oe,
  input  wire logic [7:0] a_ext,
  input  wire logic [7:0] a_load,
  input  wire logic [7:0] b_out,
  input  wire logic [7:0] b_oe,
  input  wire logic [7:0] b_ext,
  input  wire logic [7:0] b_load,
  input  wire logic       a2_out,
  input  wire logic       a2_oe,
  input  wire logic       a2_ext,
  input  wire logic       b2_out,
  input  wire logic       b2_oe,
  input  wire logic       b2_ext,
  output logic      [7:0] a_pin,
  output logic      [7:0] b_pin,
  output logic            a2_pin,
  output logic            b2_pin
);
  // ----------------------------------------
  // Pin resolution
  // ----------------------------------------
  // A heavy load drags a driven high line low at the pin.
  assign a_pin = (a_oe & a_out & ~a_load) | (~a_oe & a_ext);
  assign b_pin = (b_oe & b_out & ~b_load) | (~b_oe & b_ext);
  assign a2_pin = a2_oe ? a2_out : a2_ext;
  assign b2_pin = b2_oe ? b2_out : b2_ext;
endmodule

/* File: dv/dppa_top_tb.sv */
`timescale 1ns/1ps

module dppa_top_tb;
  import dppa_pkg::*;
  // ----------------------------------------
  // Stimulus and wiring
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  cs = 3'h0;
  logic [1:0]  sel = 2'h0;
  logic        rw = 1'b1;
  logic        stb = 1'b0;
  logic [7:0]  wdat = 8'h00;
  logic [7:0]  rdat;
  logic [7:0]  a_ext = 8'h3c;
  logic [7:0]  b_ext = 8'hc3;
  logic [7:0]  a_load = 8'h00;
  logic [7:0]  b_load = 8'h00;
  logic        c_a1 = 1'b1;
  logic        c_b1 = 1'b1;
  logic        a2_ext = 1'b0;
  logic        b2_ext = 1'b1;
  wire  [7:0]  d_out, a_out, a_oe, b_out, b_oe, a_pin, b_pin;
  wire         d_oe, ia_o, ia_e, ib_o, ib_e, a2_o, a2_e, b2_o, b2_e;
  wire         a2_pin, b2_pin;
  int          num_errors = 0;
  int          n_compared = 0;
  logic [10:0] rows [0:13];
  logic [2:0]  bad [0:2] = '{3'h2, 3'h4, 3'h7};

  always #4 clk = ~clk;

  dppa_top uut (
    .clk(clk), .rst_n(rst_n), .chip_select_0(cs[2]),
    .chip_select_1(cs[1]), .chip_select_2_n(cs[0]),
    .register_select_0(sel[0]), .register_select_1(sel[1]),
    .read_write(rw), .enable_strobe(stb), .host_data_in(wdat),
    .host_data_out(d_out), .host_data_oe(d_oe),
    .irq_side_a_n_out(ia_o), .irq_side_a_n_oe(ia_e),
    .irq_side_b_n_out(ib_o), .irq_side_b_n_oe(ib_e),
    .port_a_lines_in(a_pin), .port_a_lines_out(a_out),
    .port_a_lines_oe(a_oe), .port_b_lines_in(b_pin),
    .port_b_lines_out(b_out), .port_b_lines_oe(b_oe),
    .ctl_a1(c_a1), .ctl_b1(c_b1), .ctl_a2_in(a2_pin), .ctl_a2_out(a2_o),
    .ctl_a2_oe(a2_e), .ctl_b2_in(b2_pin), .ctl_b2_out(b2_o),
    .ctl_b2_oe(b2_e)
  );

  dppa_periph u_periph (
    .a_out(a_out), .a_oe(a_oe), .a_ext(a_ext), .a_load(a_load),
    .b_out(b_out), .b_oe(b_oe), .b_ext(b_ext), .b_load(b_load),
    .a2_out(a2_o), .a2_oe(a2_e), .a2_ext(a2_ext), .b2_out(b2_o),
    .b2_oe(b2_e), .b2_ext(b2_ext), .a_pin(a_pin), .b_pin(b_pin),
    .a2_pin(a2_pin), .b2_pin(b2_pin)
  );

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  // Chip selects stay put for three clocks after the strobe falls; register selects and data until the next cycle.
  task automatic cyc(input logic [2:0] c, input logic r,
                     input logic [1:0] s, input logic [7:0] d);
    @(negedge clk);
    cs = c;
    rw = r;
    sel = s;
    wdat = d;
    stb = 1'b1;
    repeat (2) @(negedge clk);
    chk1(d_oe, c == 3'h6 && r);
    rdat = d_out;
    stb = 1'b0;
    repeat (3) @(negedge clk);
    cs = 3'h0;
  endtask

  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    cyc(3'h6, 1'b0, s, d);
  endtask

  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    cyc(3'h6, 1'b1, s, 8'h00);
    chk8(rdat, e);
  endtask

  task automatic tally_and_finish;
    $display("errors %0d, comparisons %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    rows = '{
      {1'b0, SEL_CTRL_A, 8'h00}, {1'b0, SEL_DATA_A, 8'hf0},
      {1'b1, SEL_DATA_A, 8'hf0}, {1'b0, SEL_CTRL_A, 8'hc4},
      {1'b1, SEL_CTRL_A, 8'h04}, {1'b0, SEL_DATA_A, 8'ha5},
      {1'b1, SEL_DATA_A, 8'hac}, {1'b0, SEL_CTRL_B, 8'h00},
      {1'b0, SEL_DATA_B, 8'h0f}, {1'b1, SEL_DATA_B, 8'h0f},
      {1'b0, SEL_CTRL_B, 8'hc4}, {1'b1, SEL_CTRL_B, 8'h04},
      {1'b0, SEL_DATA_B, 8'h5a}, {1'b1, SEL_DATA_B, 8'hca}};
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      cyc(3'h6, rows[i][10], rows[i][9:8], rows[i][7:0]);
      if (rows[i][10]) begin
        chk8(rdat, rows[i][7:0]);
      end
    end
    chk8(a_oe, 8'hf0);
    chk8(b_oe, 8'h0f);
    chk8(a_out, 8'ha5);
    a_load = 8'h80;
    rd(SEL_DATA_A, 8'h2c);
    b_load = 8'h08;
    rd(SEL_DATA_B, 8'hca);
    a_load = 8'h00;
    b_load = 8'h00;
    for (int k = 0; k < 3; k++) begin
      cyc(bad[k], 1'b0, SEL_CTRL_A, 8'h3f);
      cyc(bad[k], 1'b1, SEL_DATA_A, 8'h00);
    end
    rd(SEL_CTRL_A, 8'h04);
    wr(SEL_CTRL_A, 8'h05);
    c_a1 = 1'b0;
    rd(SEL_CTRL_B, 8'h04);
    chk1(ia_e, 1'b1);
    rd(SEL_CTRL_A, 8'h85);
    rd(SEL_DATA_A, 8'hac);
    chk1(ia_e, 1'b0);
    rd(SEL_CTRL_A, 8'h05);
    wr(SEL_CTRL_A, 8'h07);
    c_a1 = 1'b1;
    repeat (2) @(negedge clk);
    c_a1 = 1'b0;
    rd(SEL_CTRL_A, 8'h07);
    wr(SEL_CTRL_A, 8'h06);
    c_a1 = 1'b1;
    rd(SEL_CTRL_B, 8'h04);
    chk1(ia_e, 1'b0);
    wr(SEL_CTRL_A, 8'h07);
    chk1(ia_e, 1'b1);
    rd(SEL_DATA_A, 8'hac);
    wr(SEL_CTRL_A, 8'h1c);
    a2_ext = 1'b1;
    rd(SEL_CTRL_B, 8'h04);
    rd(SEL_CTRL_A, 8'h5c);
    chk1(ia_e, 1'b1);
    rd(SEL_DATA_A, 8'hac);
    chk1(ia_e, 1'b0);
    wr(SEL_CTRL_B, 8'h05);
    c_b1 = 1'b0;
    rd(SEL_CTRL_A, 8'h1c);
    chk1(ib_e, 1'b1);
    rd(SEL_CTRL_B, 8'h85);
    rd(SEL_DATA_B, 8'hca);
    chk1(ib_e, 1'b0);
    wr(SEL_CTRL_A, 8'h3c);
    chk1(a2_o, 1'b1);
    chk1(a2_e, 1'b1);
    wr(SEL_CTRL_A, 8'h34);
    chk1(a2_o, 1'b0);
    wr(SEL_CTRL_A, 8'h2c);
    rd(SEL_DATA_A, 8'hac);
    chk1(a2_o, 1'b0);
    rd(SEL_CTRL_B, 8'h05);
    chk1(a2_o, 1'b1);
    wr(SEL_CTRL_B, 8'h3c);
    wr(SEL_CTRL_B, 8'h24);
    wr(SEL_DATA_B, 8'h5a);
    chk1(b2_o, 1'b1);
    rd(SEL_CTRL_A, 8'h2c);
    chk1(b2_o, 1'b0);
    c_b1 = 1'b1;
    rd(SEL_CTRL_A, 8'h2c);
    c_b1 = 1'b0;
    rd(SEL_CTRL_A, 8'h2c);
    chk1(b2_o, 1'b1);
    chk1(b2_e, 1'b1);
    rd(SEL_CTRL_B, 8'ha4);
    wr(SEL_CTRL_B, 8'h2c);
    wr(SEL_DATA_B, 8'h5a);
    chk1(b2_o, 1'b1);
    rd(SEL_CTRL_A, 8'h2c);
    chk1(b2_o, 1'b0);
    rd(SEL_CTRL_A, 8'h2c);
    chk1(b2_o, 1'b1);
    wr(SEL_CTRL_A, 8'h24);
    rd(SEL_DATA_A, 8'hac);
    chk1(a2_o, 1'b0);
    c_a1 = 1'b0;
    rd(SEL_CTRL_B, 8'hac);
    chk1(a2_o, 1'b1);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk8(a_oe, 8'h00);
    chk1(b2_e, 1'b0);
    rd(SEL_CTRL_B, 8'h00);
    rd(SEL_DATA_A, 8'h00);
    tally_and_finish();
  end
endmodule
